// *** rtl/mbs_defines.svh ***
// Purpose: Named constants of the serial slave request handler.
// Assumes: Included by the package and by the check and slave design files.
// Notes: Register numbers are 16-bit protocol register addresses.
`ifndef MBS_DEFINES_SVH
`define MBS_DEFINES_SVH

// Function codes
`define MBS_FC_RD 8'h03
`define MBS_FC_WR1 8'h06
`define MBS_FC_WRN 8'h10
`define MBS_FC_REPORT 8'h11
`define MBS_FC_MASK 8'h16
`define MBS_FC_RDWR 8'h17
`define MBS_FC_IDENT 8'h2b
`define MBS_MEI_IDENT 8'h0e
`define MBS_EXC_FLAG 8'h80

// Exchange result codes
`define MBS_EXC_OK 3'h0
`define MBS_EXC_FUNC 3'h1
`define MBS_EXC_ADDR 3'h2
`define MBS_EXC_DATA 3'h3
`define MBS_EXC_FAULT 3'h4

// Island management registers
`define MBS_REG_STATUS 16'h0384
`define MBS_REG_HALT 16'h03ed
`define MBS_REG_WDT 16'h03ee
`define MBS_REG_REARM 16'h03ef
`define MBS_REG_ORDER 16'h03f0
`define MBS_STATUS_TO_BIT 9

// Reset values
`define MBS_HALT_RST 1'b0
`define MBS_WDT_RST 16'h0000
`define MBS_ORDER_RST 1'b0

// Frame check
`define MBS_CRC_INIT 16'hffff
`define MBS_CRC_POLY 16'ha001
`define MBS_CRC_GOOD 16'h0000

// Addressing
`define MBS_BCAST 8'h00
`define MBS_NODE_MIN 8'h01
`define MBS_NODE_MAX 8'h7f

// Frame lengths in bytes, check included
`define MBS_MIN_LEN 9'h004
`define MBS_LEN_RD 9'h008
`define MBS_LEN_WR1 9'h008
`define MBS_LEN_MASK 9'h00a
`define MBS_LEN_REPORT 9'h004
`define MBS_LEN_IDENT 9'h007
`define MBS_LEN_WRN_BASE 9'h009
`define MBS_LEN_RDWR_BASE 9'h00d

// Quantity limits and byte positions
`define MBS_RD_QMAX 16'h007d
`define MBS_WR_QMAX 16'h007b
`define MBS_RW_WQMAX 16'h0079
`define MBS_HDR_N 11
`define MBS_WRN_DATA 7
`define MBS_RDWR_DATA 11
`define MBS_ECHO_SHORT 6
`define MBS_ECHO_MASK 8
`define MBS_HDR_EXC 3

// Timing
`define MBS_CLK_HZ 100000000
`define MBS_MS_PER_S 1000

`endif

// *** rtl/mbs_pkg.sv ***
// Purpose: Types shared by the request handler modules.
// Assumes: Constants come from mbs_defines.svh.
// Notes: State of mbs_crc16 and of mbs_slave is one packed struct each.
`include "mbs_defines.svh"

package mbs_pkg;

  typedef enum logic [3:0] {
    S_RX, S_CHECK, S_WF_HI, S_WF_LO, S_WF_DO, S_MASK_RD, S_MASK_DO,
    S_HDR, S_RD_ADDR, S_RD_WAIT, S_RD_LO, S_EMIT, S_CRC_LO, S_CRC_HI,
    S_DONE
  } mbs_state_e;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
    logic eof;
  } mbs_rx_s;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
    logic last;
  } mbs_tx_s;

  typedef struct packed {
    logic halt;
    logic outputs_zero;
    logic fallback;
    logic word_swap;
  } mbs_island_s;

  typedef struct packed {
    logic done;
    logic [2:0] code;
  } mbs_result_s;

  typedef struct packed {
    logic [15:0] crc;
  } mbs_crc_s;

  typedef struct packed {
    mbs_state_e state;
    mbs_state_e ret;
    logic armed;
    logic [7:0] node;
    logic [8:0] len;
    logic ovf;
    logic [`MBS_HDR_N-1:0][7:0] hdr;
    logic [8:0] k;
    logic [7:0] wcnt;
    logic [15:0] radr;
    logic [15:0] word;
    logic [7:0] tx_byte;
    logic [2:0] exc;
    logic bcast;
    logic crc_ph;
    logic halt;
    logic [15:0] wdt;
    logic order;
    logic tmo;
    logic [16:0] pre;
    logic [15:0] ms;
    logic done;
  } mbs_core_s;

endpackage

// *** rtl/mbs_crc16.sv ***
// Purpose: Byte-wise frame check accumulator.
// Assumes: Clear and enable never needed in the same cycle.
// Notes: Residue over a whole good frame is zero.
`timescale 1ns/1ps
`include "mbs_defines.svh"

module mbs_crc16 (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Byte feed
  input wire logic clear_i,
  input wire logic en_i,
  input wire logic [7:0] byte_i,
  // Result
  output logic [15:0] crc_o
);

  mbs_pkg::mbs_crc_s q, d;
  logic [15:0] c;

  always_comb
  begin
    d = q;
    c = q.crc ^ {8'h00, byte_i};
    for (int i = 0; i < 8; i++)
    begin
      c = c[0] ? ((c >> 1) ^ `MBS_CRC_POLY) : (c >> 1);
    end
    if (clear_i)
      d.crc = `MBS_CRC_INIT;
    else if (en_i)
      d.crc = c;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      q.crc <= `MBS_CRC_INIT;
    else
      q <= d;
  end

  assign crc_o = q.crc;

endmodule

// *** rtl/mbs_mem.sv ***
// Purpose: Small word memory with registered read data.
// Assumes: One write and one read port, same clock.
// Notes: Cleared at reset so reads never return unknowns.
`timescale 1ns/1ps

module mbs_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Write port
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  // Read port
  input wire logic [AW-1:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] rdata_q;

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem[i] <= '0;
      rdata_q <= '0;
    end
    else
    begin
      if (we_i)
        mem[waddr_i] <= wdata_i;
      rdata_q <= mem[raddr_i];
    end
  end

  assign rdata_o = rdata_q;

endmodule

// *** rtl/mbs_slave.sv ***
// Purpose: Serial slave request handler with island management registers.
// Assumes: Bytes and end-of-frame marks come from a framing receiver.
// Notes: Requests arriving while a response is in progress are ignored.
`timescale 1ns/1ps
`include "mbs_defines.svh"

// Overview of operation
// - Answer only individually addressed requests; act silently on broadcast.
// - Every register is one 16-bit word, sent high byte first.
// - Frame is address, function, data, then two check bytes.
// - Result codes: 0 ok, 1 function, 2 register, 3 data, 4 fault.
// - Accept codes 3, 6, 16, 17, 22, 23 and 43/14 only.
// - Code 3 returns consecutive registers from the start register.
// - Code 6 stores one value into the addressed register.
// - Code 16 stores consecutive values from the start register.
// - Multi-register ranges must be contiguous and fully valid.
// - Code 22 writes (cur AND and) OR (or AND NOT and).
// - Code 23 writes first, then returns the read range.
// - Code 43/14 returns identification objects 0, 1, 2 and 4.
// - Code 17 returns a fixed block reference text.
// - Nonzero write to halt register stops the internal bus.
// - While halted, expansion outputs are forced to zero.
// - Zero write to halt register is refused if parameters invalid.
// - Word order bit 0 selects 32-bit word order, default zero.
// - Watchdog time in ms, zero disables monitoring.
// - No frame before timeout makes outputs go to fallback.
// - Timeout sets status register bit 9.
// - Writing zero to rearm register clears bit 9 and rearms.
// - Node address 1 to 127; respond only to own address.
module mbs_slave #(
  parameter int REG_DEPTH = 64,
  parameter int REG_AW = 6,
  parameter int FB_DEPTH = 256,
  parameter int FB_AW = 8,
  parameter int CYC_PER_MS = `MBS_CLK_HZ / `MBS_MS_PER_S,
  parameter int REPORT_LEN = 8,
  // Arbitrary text
  parameter logic [8*REPORT_LEN-1:0] REPORT_TXT = "BLOCKREF",
  parameter int OBJ_LEN = 28,
  // Arbitrary identification strings and version
  parameter logic [8*OBJ_LEN-1:0] OBJ_BODY = {
    8'h0e, 8'h01, 8'h01, 8'h00, 8'h00, 8'h04,
    8'h00, 8'h04, "ACME", 8'h01, 8'h04, "P000",
    8'h02, 8'h02, 8'h02, 8'h07, 8'h04, 8'h04, "UNIT"}
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Straps and island status
  input wire logic [7:0] node_addr_i,
  input wire logic param_invalid_i,
  // Receive stream
  input wire mbs_pkg::mbs_rx_s rx_i,
  // Transmit stream
  input wire logic tx_ready_i,
  output mbs_pkg::mbs_tx_s tx_o,
  // Island control and result
  output mbs_pkg::mbs_island_s island_o,
  output mbs_pkg::mbs_result_s result_o
);

  mbs_pkg::mbs_core_s q, d;
  logic [7:0] fc;
  logic [15:0] f_a, f_b, f_c, f_d;
  logic [15:0] crc, reg_rdata, rdval, status_w;
  logic [7:0] fb_rdata, hbyte;
  logic [8:0] hlen;
  logic crc_clr, crc_en, fb_we, reg_we, wr_en, node_ok, frame_ok;
  logic wd_clear, wd_rearm, wd_expire;
  logic [15:0] wr_addr, wr_val;
  logic [2:0] chk_exc;

  assign fc = q.hdr[1];
  assign f_a = {q.hdr[2], q.hdr[3]};
  assign f_b = {q.hdr[4], q.hdr[5]};
  assign f_c = {q.hdr[6], q.hdr[7]};
  assign f_d = {q.hdr[8], q.hdr[9]};

  function automatic logic range_ok(input logic [15:0] s,
                                    input logic [15:0] n);
    logic [16:0] e;
    e = {1'b0, s} + {1'b0, n};
    range_ok = (e <= 17'(REG_DEPTH)) ||
               (s == `MBS_REG_STATUS && n == 16'h0001) ||
               (s >= `MBS_REG_HALT &&
                e <= ({1'b0, `MBS_REG_ORDER} + 17'h00001));
  endfunction

  // Check runs over received bytes, then over transmitted ones
  assign crc_clr = (q.state == mbs_pkg::S_CHECK) ||
                   (q.state == mbs_pkg::S_DONE);
  assign crc_en = ((q.state == mbs_pkg::S_RX) && rx_i.valid) ||
                  ((q.state == mbs_pkg::S_EMIT) && tx_ready_i &&
                   !q.crc_ph);

  mbs_crc16 u_crc (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .clear_i(crc_clr),
    .en_i(crc_en),
    .byte_i((q.state == mbs_pkg::S_RX) ? rx_i.data : q.tx_byte),
    .crc_o(crc)
  );

  assign fb_we = (q.state == mbs_pkg::S_RX) && rx_i.valid &&
                 (q.len < 9'(FB_DEPTH));

  mbs_mem #(.WIDTH(8), .DEPTH(FB_DEPTH), .AW(FB_AW)) u_frame (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .we_i(fb_we),
    .waddr_i(q.len[FB_AW-1:0]),
    .wdata_i(rx_i.data),
    .raddr_i(q.k[FB_AW-1:0]),
    .rdata_o(fb_rdata)
  );

  assign reg_we = wr_en && (wr_addr < 16'(REG_DEPTH));

  mbs_mem #(.WIDTH(16), .DEPTH(REG_DEPTH), .AW(REG_AW)) u_regs (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .we_i(reg_we),
    .waddr_i(wr_addr[REG_AW-1:0]),
    .wdata_i(wr_val),
    .raddr_i(q.radr[REG_AW-1:0]),
    .rdata_o(reg_rdata)
  );

  // Register read value for the current register number
  always_comb
  begin
    status_w = 16'h0000;
    status_w[`MBS_STATUS_TO_BIT] = q.tmo;
    case (q.radr)
      `MBS_REG_STATUS: rdval = status_w;
      `MBS_REG_HALT: rdval = {15'h0000, q.halt};
      `MBS_REG_WDT: rdval = q.wdt;
      `MBS_REG_ORDER: rdval = {15'h0000, q.order};
      default: rdval = 16'h0000;
    endcase
    if (q.radr < 16'(REG_DEPTH))
      rdval = reg_rdata;
  end

  // Frame acceptance and request validation
  always_comb
  begin
    node_ok = (q.node >= `MBS_NODE_MIN) && (q.node <= `MBS_NODE_MAX);
    frame_ok = !q.ovf && (q.len >= `MBS_MIN_LEN) &&
               (crc == `MBS_CRC_GOOD) && node_ok &&
               (q.hdr[0] == q.node || q.hdr[0] == `MBS_BCAST);
    chk_exc = `MBS_EXC_OK;
    case (fc)
      `MBS_FC_RD:
        if (q.len != `MBS_LEN_RD || f_b == 16'h0000 || f_b > `MBS_RD_QMAX)
          chk_exc = `MBS_EXC_DATA;
        else if (!range_ok(f_a, f_b))
          chk_exc = `MBS_EXC_ADDR;
      `MBS_FC_WR1:
        if (q.len != `MBS_LEN_WR1)
          chk_exc = `MBS_EXC_DATA;
        else if (!range_ok(f_a, 16'h0001))
          chk_exc = `MBS_EXC_ADDR;
        else if (f_a == `MBS_REG_HALT && f_b == 16'h0000 && param_invalid_i)
          chk_exc = `MBS_EXC_FAULT;
      `MBS_FC_WRN:
        if (q.len != (`MBS_LEN_WRN_BASE + {f_b[7:0], 1'b0}) ||
            f_b == 16'h0000 || f_b > `MBS_WR_QMAX ||
            q.hdr[6] != {f_b[6:0], 1'b0})
          chk_exc = `MBS_EXC_DATA;
        else if (!range_ok(f_a, f_b))
          chk_exc = `MBS_EXC_ADDR;
      `MBS_FC_MASK:
        if (q.len != `MBS_LEN_MASK)
          chk_exc = `MBS_EXC_DATA;
        else if (!range_ok(f_a, 16'h0001))
          chk_exc = `MBS_EXC_ADDR;
      `MBS_FC_RDWR:
        if (q.len != (`MBS_LEN_RDWR_BASE + {f_d[7:0], 1'b0}) ||
            f_b == 16'h0000 || f_b > `MBS_RD_QMAX ||
            f_d == 16'h0000 || f_d > `MBS_RW_WQMAX ||
            q.hdr[10] != {f_d[6:0], 1'b0})
          chk_exc = `MBS_EXC_DATA;
        else if (!range_ok(f_a, f_b) || !range_ok(f_c, f_d))
          chk_exc = `MBS_EXC_ADDR;
      `MBS_FC_REPORT:
        if (q.len != `MBS_LEN_REPORT)
          chk_exc = `MBS_EXC_DATA;
      `MBS_FC_IDENT:
        if (q.hdr[2] != `MBS_MEI_IDENT)
          chk_exc = `MBS_EXC_FUNC;
        else if (q.len != `MBS_LEN_IDENT)
          chk_exc = `MBS_EXC_DATA;
      default: chk_exc = `MBS_EXC_FUNC;
    endcase
  end

  // Response header bytes, before any register data
  always_comb
  begin
    hlen = 9'(`MBS_ECHO_SHORT);
    hbyte = (q.k < 9'(`MBS_HDR_N)) ? q.hdr[q.k[3:0]] : 8'h00;
    if (q.exc != `MBS_EXC_OK)
    begin
      hlen = 9'(`MBS_HDR_EXC);
      if (q.k == 9'h001)
        hbyte = fc | `MBS_EXC_FLAG;
      else if (q.k == 9'h002)
        hbyte = {5'h00, q.exc};
    end
    else
      case (fc)
        `MBS_FC_RD, `MBS_FC_RDWR:
        begin
          hlen = 9'(`MBS_HDR_EXC);
          if (q.k == 9'h002)
            hbyte = {q.wcnt[6:0], 1'b0};
        end
        `MBS_FC_MASK: hlen = 9'(`MBS_ECHO_MASK);
        `MBS_FC_REPORT:
        begin
          hlen = 9'(REPORT_LEN + 3);
          if (q.k == 9'h002)
            hbyte = 8'(REPORT_LEN);
          else if (q.k > 9'h002 && q.k < hlen)
            hbyte = REPORT_TXT[8*(REPORT_LEN+2-int'(q.k)) +: 8];
        end
        `MBS_FC_IDENT:
        begin
          hlen = 9'(OBJ_LEN + 2);
          if (q.k > 9'h001 && q.k < hlen)
            hbyte = OBJ_BODY[8*(OBJ_LEN+1-int'(q.k)) +: 8];
        end
        default: ;
      endcase
  end

  // Sequencer, register writes and network watchdog
  always_comb
  begin
    d = q;
    d.done = 1'b0;
    wr_en = 1'b0;
    wr_addr = q.radr;
    wr_val = 16'h0000;
    if (!q.armed)
    begin
      d.armed = 1'b1;
      d.node = node_addr_i;
    end
    case (q.state)
      mbs_pkg::S_RX:
      begin
        if (rx_i.valid)
        begin
          if (q.len < 9'(`MBS_HDR_N))
            d.hdr[q.len[3:0]] = rx_i.data;
          if (q.len == 9'(FB_DEPTH))
            d.ovf = 1'b1;
          else
            d.len = q.len + 9'h001;
        end
        if (rx_i.eof)
          d.state = mbs_pkg::S_CHECK;
      end
      mbs_pkg::S_CHECK:
      begin
        d.bcast = (q.hdr[0] == `MBS_BCAST);
        d.exc = chk_exc;
        d.k = 9'h000;
        d.radr = f_a;
        d.wcnt = f_b[7:0];
        if (!frame_ok)
        begin
          d.state = mbs_pkg::S_RX;
          d.len = 9'h000;
          d.ovf = 1'b0;
        end
        else if (chk_exc != `MBS_EXC_OK)
          d.state = mbs_pkg::S_HDR;
        else
          case (fc)
            `MBS_FC_WR1:
            begin
              wr_en = 1'b1;
              wr_addr = f_a;
              wr_val = f_b;
              d.state = mbs_pkg::S_HDR;
            end
            `MBS_FC_WRN:
            begin
              d.k = 9'(`MBS_WRN_DATA);
              d.state = mbs_pkg::S_WF_HI;
            end
            `MBS_FC_RDWR:
            begin
              d.radr = f_c;
              d.wcnt = f_d[7:0];
              d.k = 9'(`MBS_RDWR_DATA);
              d.state = mbs_pkg::S_WF_HI;
            end
            `MBS_FC_MASK: d.state = mbs_pkg::S_MASK_RD;
            default: d.state = mbs_pkg::S_HDR;
          endcase
      end
      mbs_pkg::S_WF_HI:
      begin
        d.k = q.k + 9'h001;
        d.state = mbs_pkg::S_WF_LO;
      end
      mbs_pkg::S_WF_LO:
      begin
        d.word[15:8] = fb_rdata;
        d.k = q.k + 9'h001;
        d.state = mbs_pkg::S_WF_DO;
      end
      mbs_pkg::S_WF_DO:
      begin
        wr_en = 1'b1;
        wr_val = {q.word[15:8], fb_rdata};
        d.radr = q.radr + 16'h0001;
        d.wcnt = q.wcnt - 8'h01;
        d.state = mbs_pkg::S_WF_HI;
        if (q.wcnt == 8'h01)
        begin
          d.radr = f_a;
          d.wcnt = f_b[7:0];
          d.k = 9'h000;
          d.state = mbs_pkg::S_HDR;
        end
      end
      mbs_pkg::S_MASK_RD: d.state = mbs_pkg::S_MASK_DO;
      mbs_pkg::S_MASK_DO:
      begin
        wr_en = 1'b1;
        wr_val = (rdval & f_b) | (f_c & ~f_b);
        d.k = 9'h000;
        d.state = mbs_pkg::S_HDR;
      end
      mbs_pkg::S_HDR:
        if (q.bcast)
          d.state = mbs_pkg::S_DONE;
        else if (q.k < hlen)
        begin
          d.tx_byte = hbyte;
          d.k = q.k + 9'h001;
          d.ret = mbs_pkg::S_HDR;
          d.state = mbs_pkg::S_EMIT;
        end
        else if (q.exc == `MBS_EXC_OK &&
                 (fc == `MBS_FC_RD || fc == `MBS_FC_RDWR))
          d.state = mbs_pkg::S_RD_ADDR;
        else
          d.state = mbs_pkg::S_CRC_LO;
      mbs_pkg::S_RD_ADDR: d.state = mbs_pkg::S_RD_WAIT;
      mbs_pkg::S_RD_WAIT:
      begin
        d.word = rdval;
        d.tx_byte = rdval[15:8];
        d.ret = mbs_pkg::S_RD_LO;
        d.state = mbs_pkg::S_EMIT;
      end
      mbs_pkg::S_RD_LO:
      begin
        d.tx_byte = q.word[7:0];
        d.radr = q.radr + 16'h0001;
        d.wcnt = q.wcnt - 8'h01;
        d.ret = (q.wcnt == 8'h01) ? mbs_pkg::S_CRC_LO : mbs_pkg::S_RD_ADDR;
        d.state = mbs_pkg::S_EMIT;
      end
      mbs_pkg::S_EMIT:
        if (tx_ready_i)
          d.state = q.ret;
      mbs_pkg::S_CRC_LO:
      begin
        d.tx_byte = crc[7:0];
        d.word = crc;
        d.crc_ph = 1'b1;
        d.ret = mbs_pkg::S_CRC_HI;
        d.state = mbs_pkg::S_EMIT;
      end
      mbs_pkg::S_CRC_HI:
      begin
        d.tx_byte = q.word[15:8];
        d.ret = mbs_pkg::S_DONE;
        d.state = mbs_pkg::S_EMIT;
      end
      mbs_pkg::S_DONE:
      begin
        d.done = 1'b1;
        d.crc_ph = 1'b0;
        d.len = 9'h000;
        d.ovf = 1'b0;
        d.state = mbs_pkg::S_RX;
      end
      default: d.state = mbs_pkg::S_RX;
    endcase

    if (wr_en)
      case (wr_addr)
        `MBS_REG_HALT:
          if (!(wr_val == 16'h0000 && param_invalid_i))
            d.halt = (wr_val != 16'h0000);
        `MBS_REG_WDT: d.wdt = wr_val;
        `MBS_REG_ORDER: d.order = wr_val[0];
        default: ;
      endcase

    // Any frame on the line restarts the count, even if not for us
    wd_rearm = wr_en && (wr_addr == `MBS_REG_REARM) &&
               (wr_val == 16'h0000);
    wd_clear = rx_i.eof || wd_rearm ||
               (wr_en && wr_addr == `MBS_REG_WDT);
    wd_expire = (q.wdt != 16'h0000) && !q.tmo &&
                (q.pre == 17'(CYC_PER_MS - 1)) &&
                (16'(q.ms + 16'h0001) == q.wdt);
    if (wd_clear)
    begin
      d.pre = 17'h00000;
      d.ms = 16'h0000;
    end
    else if (q.wdt != 16'h0000 && !q.tmo)
    begin
      if (q.pre == 17'(CYC_PER_MS - 1))
      begin
        d.pre = 17'h00000;
        d.ms = q.ms + 16'h0001;
      end
      else
        d.pre = q.pre + 17'h00001;
    end
    if (wd_rearm)
      d.tmo = 1'b0;
    // Expiry wins over a rearm in the same cycle
    if (wd_expire)
      d.tmo = 1'b1;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.state <= mbs_pkg::S_RX;
      q.ret <= mbs_pkg::S_RX;
      q.halt <= `MBS_HALT_RST;
      q.wdt <= `MBS_WDT_RST;
      q.order <= `MBS_ORDER_RST;
    end
    else
      q <= d;
  end

  assign tx_o.data = q.tx_byte;
  assign tx_o.valid = (q.state == mbs_pkg::S_EMIT);
  assign tx_o.last = (q.state == mbs_pkg::S_EMIT) && q.crc_ph &&
                     (q.ret == mbs_pkg::S_DONE);
  assign island_o.halt = q.halt;
  assign island_o.outputs_zero = q.halt;
  assign island_o.fallback = q.tmo;
  assign island_o.word_swap = q.order;
  assign result_o.done = q.done;
  assign result_o.code = q.exc;

endmodule

// *** tb/mbs_slave_chk.sv ***
// Purpose: Port checker for the request handler
// Assumes: Single clock, synchronous reset
// Notes: Bound to every mbs_slave instance
`timescale 1ns/1ps
module mbs_slave_chk (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Inputs
  input wire logic [7:0] node_addr_i,
  input wire logic param_invalid_i,
  input wire mbs_pkg::mbs_rx_s rx_i,
  input wire logic tx_ready_i,
  // Outputs
  input wire mbs_pkg::mbs_tx_s tx_o,
  input wire mbs_pkg::mbs_island_s island_o,
  input wire mbs_pkg::mbs_result_s result_o
);
  logic busy_q;
  logic busy_d;
  // Open from a frame end until done; a reply outside it is unasked
  always_comb
  begin
    busy_d = busy_q;
    if (rx_i.eof)
      busy_d = 1'b1;
    if (result_o.done)
      busy_d = 1'b0;
  end
  always_ff @(posedge ref_clk_i)
    busy_q <= rst_i ? 1'b0 : busy_d;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  a_tx_hold: assert property (
    tx_o.valid && !tx_ready_i |=> tx_o.valid && $stable(tx_o.data))
    else $error("tx byte changed");
  a_tx_gap: assert property (
    tx_o.valid && tx_ready_i |=> !tx_o.valid)
    else $error("tx no prep gap");
  a_reply_asked: assert property (
    tx_o.valid |-> busy_q)
    else $error("unasked reply");
  a_last_done: assert property (
    tx_o.valid && tx_o.last && tx_ready_i |-> ##[1:4] result_o.done)
    else $error("no done after last");
  a_done_pulse: assert property (
    result_o.done |=> !result_o.done)
    else $error("done too long");
  a_code_range: assert property (
    result_o.done |-> result_o.code <= 3'h4)
    else $error("bad result code");
  a_zero_outs: assert property (
    island_o.outputs_zero == island_o.halt)
    else $error("outputs not zeroed");
  a_halt_refused: assert property (
    $fell(island_o.halt) |-> !param_invalid_i)
    else $error("restart while invalid");
  a_halt_by_write: assert property (
    $rose(island_o.halt) |-> ##[1:100] result_o.done)
    else $error("halt without request");
  a_rearm_write: assert property (
    $fell(island_o.fallback) |-> ##[1:100] result_o.done)
    else $error("rearm without request");
  a_order_write: assert property (
    $changed(island_o.word_swap) |-> ##[1:100] result_o.done)
    else $error("order without request");
endmodule

bind mbs_slave mbs_slave_chk u_chk (.ref_clk_i(ref_clk_i),
  .rst_i(rst_i), .node_addr_i(node_addr_i),
  .param_invalid_i(param_invalid_i), .rx_i(rx_i),
  .tx_ready_i(tx_ready_i), .tx_o(tx_o), .island_o(island_o),
  .result_o(result_o));

// *** tb/mbs_master.sv ***
// Purpose: Single bus master model
// Assumes: Inputs driven at the falling edge
// Notes: Slow mode is ready for reply bytes only every other cycle
`timescale 1ns/1ps
module mbs_master (
  // Clock
  input wire logic ref_clk_i,
  // Requests
  output mbs_pkg::mbs_rx_s rx_o,
  // Replies
  input wire mbs_pkg::mbs_tx_s tx_i,
  output logic tx_ready_o
);
  logic [7:0] rsp[$];
  logic slow = 1'b0;
  logic ph = 1'b0;
  int lastpos = 0;
  initial rx_o = '0;
  initial tx_ready_o = 1'b0;
  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i])
    begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction
  // Only this model originates frames
  task automatic send(input logic [7:0] q[$], input logic bad);
    logic [15:0] c;
    c = crc(q) ^ {15'h0000, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    rsp.delete();
    lastpos = 0;
    foreach (q[i])
    begin
      @(negedge ref_clk_i);
      rx_o = '{data: q[i], valid: 1'b1, eof: 1'b0};
    end
    // Released data line shows the inverse, never a stale byte
    @(negedge ref_clk_i);
    rx_o = '{data: ~rx_o.data, valid: 1'b0, eof: 1'b1};
    @(negedge ref_clk_i);
    rx_o.eof = 1'b0;
  endtask
  always @(negedge ref_clk_i)
  begin
    ph <= !ph;
    tx_ready_o <= !slow || ph;
  end
  always @(posedge ref_clk_i)
    if (tx_i.valid && tx_ready_o)
    begin
      rsp.push_back(tx_i.data);
      // Positions add up, so an early flag shows
      if (tx_i.last)
        lastpos += rsp.size();
    end
endmodule

// *** tb/tb_mbs_slave.sv ***
// Purpose: Self-checking bench of the request handler
// Assumes: Node address 1, one millisecond is 10 cycles
// Notes: Replies compared byte by byte, check included
`timescale 1ns/1ps
`define CHK(a, e) \
  begin \
    comparisons++; \
    if ((a) !== (e)) \
    begin \
      miscompares++; \
      $display("[ERR] %0t got %h exp %h", $time, a, e); \
    end \
  end
module tb_mbs_slave;
  typedef logic [7:0] mbs_q_t[$];
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic inval = 1'b0;
  logic [7:0] node = 8'h01;
  logic rdy;
  mbs_pkg::mbs_rx_s rx;
  mbs_pkg::mbs_tx_s tx;
  mbs_pkg::mbs_island_s isl;
  mbs_pkg::mbs_result_s res;
  int miscompares = 0;
  int comparisons = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  mbs_slave #(.CYC_PER_MS(10)) DUT (.ref_clk_i(ref_clk_i),
    .rst_i(rst_i), .node_addr_i(node), .param_invalid_i(inval),
    .rx_i(rx), .tx_ready_i(rdy), .tx_o(tx), .island_o(isl),
    .result_o(res));
  mbs_master m (.ref_clk_i(ref_clk_i), .rx_o(rx), .tx_i(tx),
    .tx_ready_o(rdy));
  function automatic mbs_q_t bytes(input logic [255:0] v, input int n);
    mbs_q_t q;
    for (int i = n - 1; i >= 0; i--)
      q.push_back(v[8*i +: 8]);
    return q;
  endfunction
  // One request; an empty reply means silence expected
  task automatic xact(input logic [255:0] q, input int qn,
    input logic [255:0] e, input int en, input logic drop = 1'b0,
    input logic bad = 1'b0);
    mbs_q_t eq;
    logic [15:0] c;
    int n;
    eq = bytes(e, en);
    n = 0;
    m.send(bytes(q, qn), bad);
    while (res.done !== 1'b1 && n < 300)
    begin
      @(negedge ref_clk_i);
      n++;
    end
    `CHK(res.done, !drop)
    if (en > 0)
    begin
      c = m.crc(eq);
      eq.push_back(c[7:0]);
      eq.push_back(c[15:8]);
    end
    `CHK(m.rsp.size(), eq.size())
    `CHK(m.lastpos, eq.size())
    foreach (eq[i])
      `CHK(m.rsp[i], eq[i])
    if (!drop)
      `CHK(res.code, (en == 3 && e[15]) ? e[2:0] : 3'h0)
    @(negedge ref_clk_i);
  endtask
  task automatic t_regs;
    xact(48'h01060005_1234, 6, 48'h01060005_1234, 6);
    xact(48'h01030004_0002, 6, 56'h010304_0000_1234, 7);
    xact(48'h01030384_0002, 6, 24'h018302, 3);
    xact(48'h0103003f_0002, 6, 24'h018302, 3);
    xact(48'h01030004_0000, 6, 24'h018303, 3);
  endtask
  task automatic t_multi;
    m.slow = 1'b1;
    xact(88'h0110000a_0002_04_0012_5678, 11, 48'h0110000a0002, 6);
    xact(64'h0116000a_00f2_0025, 8, 64'h0116000a_00f2_0025, 8);
    xact(48'h0103000a_0002, 6, 56'h010304_0017_5678, 7);
    xact(104'h01170014_0001_0014_0001_02_abcd, 13,
      40'h011702_abcd, 5);
    m.slow = 1'b0;
  endtask
  task automatic t_ident;
    logic [7:0] fcs[4] = '{8'h01, 8'h04, 8'h07, 8'h2a};
    xact(16'h0111, 2, {24'h011108, "BLOCKREF"}, 11);
    xact(40'h012b0e0100, 5, {16'h012b, 48'h0e0101000004, 16'h0004,
      "ACME", 16'h0104, "P000", 48'h020202070404, "UNIT"}, 30);
    xact(40'h012b0d0100, 5, 24'h01ab01, 3);
    foreach (fcs[i])
      xact({8'h01, fcs[i], 32'h0001}, 6,
        {8'h01, fcs[i] | 8'h80, 8'h01}, 3);
  endtask
  task automatic t_addr;
    xact(48'h00060006_0055, 6, 0, 0);
    xact(48'h01030006_0001, 6, 40'h010302_0055, 5);
    xact(48'h02030006_0001, 6, 0, 0, 1'b1);
    xact(48'h01030006_0001, 6, 0, 0, 1'b1, 1'b1);
  endtask
  task automatic t_island;
    xact(48'h010303f0_0001, 6, 40'h010302_0000, 5);
    xact(48'h010303ee_0001, 6, 40'h010302_0000, 5);
    xact(48'h010603ed_0001, 6, 48'h010603ed_0001, 6);
    `CHK(isl.outputs_zero, 1'b1)
    inval = 1'b1;
    xact(48'h010603ed_0000, 6, 24'h018604, 3);
    `CHK(isl.halt, 1'b1)
    inval = 1'b0;
    xact(48'h010603ed_0000, 6, 48'h010603ed_0000, 6);
    `CHK(isl.halt, 1'b0)
    xact(48'h010603f0_0001, 6, 48'h010603f0_0001, 6);
    `CHK(isl.word_swap, 1'b1)
  endtask
  task automatic t_wdog;
    xact(48'h010603ee_000a, 6, 48'h010603ee_000a, 6);
    `CHK(isl.fallback, 1'b0)
    repeat (150) @(negedge ref_clk_i);
    `CHK(isl.fallback, 1'b1)
    xact(48'h01030384_0001, 6, 40'h010302_0200, 5);
    xact(48'h010603ef_0000, 6, 48'h010603ef_0000, 6);
    `CHK(isl.fallback, 1'b0)
    xact(48'h010603ee_0000, 6, 48'h010603ee_0000, 6);
  endtask
  // Strap is read only after reset; two edges keep checks quiet
  task automatic t_node;
    node = 8'h80;
    rst_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    rst_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    xact(48'h80030006_0001, 6, 0, 0, 1'b1);
    xact(48'h00060006_0077, 6, 0, 0, 1'b1);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    miscompares++;
    wrap_up();
  end
  initial
  begin
    repeat (10) @(negedge ref_clk_i);
    rst_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    t_regs();
    t_multi();
    t_ident();
    t_addr();
    t_island();
    t_wdog();
    t_node();
    wrap_up();
  end
endmodule
